// >>> include/flash_status_consts.svh
// Command codes, status bit positions, reset values and timing counts
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH
`define CMD_READ_STATUS     8'h05
`define CMD_READ_STATUS_TWO 8'h07
`define CMD_WRITE_ENABLE    8'h06
`define CMD_WRITE_DISABLE   8'h04
`define CMD_REGISTER_WRITE  8'h01
`define CMD_CLEAR_STATUS    8'h30
`define CMD_PROGRAM         8'h02
`define CMD_SECTOR_ERASE    8'hd8
`define CMD_WHOLE_ERASE     8'hc7
`define CMD_ERASE_SUSPEND   8'h75
`define CMD_PROGRAM_SUSPEND 8'h85
`define CMD_SOFT_RESET      8'hf0
`define SB_LOCK             7
`define SB_PERR             6
`define SB_EERR             5
`define SB_PROT_HI          4
`define SB_PROT_LO          2
`define SB_WEL              1
`define SB_BUSY             0
`define PROT_VOL_RST        3'h7
`define PROT_NV_RST         3'h0
`define PROT_NONE           3'h0
`define SYNC_RST            3'h4
`define CMD_BITS_ONE        5'h07
`define CMD_BITS_TWO        5'h0f
`define CMD_BITS_MAX        5'h10
`define RD_BIT_LAST         3'h7
`define CLK_PERIOD_NS       8
`define REG_WRITE_TIME_NS   1000
`define REG_WRITE_CYCLES    ((`REG_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> include/flash_status_pkg.sv
// Types shared by the status register logic
package flash_status_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_REG   = 4'h2,
        ST_ARRAY = 4'h4,
        ST_HALT  = 4'h8
    } op_state_t;
    typedef enum logic [1:0] {
        KIND_PROG = 2'h0,
        KIND_SECT = 2'h1,
        KIND_BULK = 2'h2
    } op_kind_t;
endpackage : flash_status_pkg

// >>> logic/flash_status_register_logic.sv
// Status byte logic of a serial flash: link shifter, command filter, latch and flags
// What this block does
// R01: Command 05h returns lock, two error flags, three protect bits, latch, busy.
// R02: Command 06h sets the write enable latch, 04h clears it.
// R03: Register write, program and erase are ignored unless the latch is one.
// R04: Register write never loads the write enable latch.
// R05: Successful program, register write or erase clears the latch on completion.
// R06: Power-on, hardware and software reset leave the latch at zero.
// R07: Host clears status then disables writes after a failure to drop the latch.
// R08: Lock bit one with protect pin low refuses register write commands.
// R09: Protect pin high or lock bit zero lets register write change lock and protect bits.
// R10: Program failure or program into protected area sets the program error flag.
// R11: Erase failure or erase of a protected sector sets the erase error flag.
// R12: Whole-array erase meeting protection does not set the erase error flag.
// R13: Error flags ignore register write; only clear-status and reset clear them.
// R14: Protect bits are volatile or non-volatile per the volatility select.
// R15: Volatile protect bits default to one, non-volatile ones ship as zero.
// R16: Protected area refuses program and erase; whole erase needs all protect bits zero.
// R17: While busy only status reads, suspends, clear-status and reset are taken.
// R18: Suspend commands are taken only during the matching array operation.
// R19: An error flag keeps busy set until a clear-status command or a reset.
// R20: Volatile defaults apply after every kind of reset.
// R21: Configuration freeze holds the protect bits against register write while its input is high; resets still apply.
// R22: Sector protection decode arrives as an external input.
// R23: Status reads return live bit values, also while busy.
module flash_status_register_logic
    import flash_status_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic mosi_i,
    input  wire logic wp_n_i,
    input  wire logic protect_volatility_sel_i,
    input  wire logic config_freeze_i,
    input  wire logic sector_protected_i,
    input  wire logic op_done_i,
    input  wire logic op_fail_i,
    output logic       miso_o,
    output logic       miso_oe_o,
    output logic [7:0] status_byte_o,
    output logic       op_start_o,
    output op_kind_t   op_kind_o,
    output logic       erase_suspend_o,
    output logic       program_suspend_o
);
`include "flash_status_consts.svh"

    function automatic logic busy_ok(input logic [7:0] c);
        busy_ok = (c == `CMD_READ_STATUS) || (c == `CMD_READ_STATUS_TWO)
               || (c == `CMD_CLEAR_STATUS) || (c == `CMD_ERASE_SUSPEND)
               || (c == `CMD_PROGRAM_SUSPEND) || (c == `CMD_SOFT_RESET);
    endfunction : busy_ok

    function automatic logic is_array(input logic [7:0] c);
        is_array = (c == `CMD_PROGRAM) || (c == `CMD_SECTOR_ERASE)
                || (c == `CMD_WHOLE_ERASE);
    endfunction : is_array

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: shifter, command hand-off, status snapshot, data out
    // Frame logic is cleared while chip select is high, since sck stops there
    wire        link_rst_n = resetn_i & ~cs_n_i;
    logic [4:0] bit_cnt_r;
    logic [15:0] shift_r;
    logic [7:0] cmd_hold_r;
    logic [7:0] data_hold_r;
    logic       cmd_tgl_r;
    logic [2:0] lq_r;
    logic       link_ack_r;
    logic [7:0] snap_r;
    logic       rd_r;
    logic [2:0] rd_cnt_r;
    logic [7:0] out_sh_r;
    logic [7:0] st_word_r;
    logic       st_req_r;

    wire [7:0] byte_in  = {shift_r[6:0], mosi_i};
    wire       fire_one = (bit_cnt_r == `CMD_BITS_ONE) && (byte_in != `CMD_REGISTER_WRITE);
    wire       fire_two = (bit_cnt_r == `CMD_BITS_TWO)
                       && (shift_r[14:7] == `CMD_REGISTER_WRITE);
    wire       rd_start = (bit_cnt_r == `CMD_BITS_ONE)
                       && ((byte_in == `CMD_READ_STATUS) || (byte_in == `CMD_READ_STATUS_TWO));
    wire       lq_new   = (lq_r[1] == lq_r[2]) && (lq_r[2] != link_ack_r);
    wire [4:0] bit_cnt_nxt = (bit_cnt_r == `CMD_BITS_MAX) ? bit_cnt_r : bit_cnt_r + 5'h1;

    always_ff @(posedge sck_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_r <= 5'h0;
            shift_r   <= 16'h0;
            rd_r      <= 1'b0;
            rd_cnt_r  <= 3'h0;
            out_sh_r  <= 8'h0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            shift_r   <= {shift_r[14:0], mosi_i};
            rd_r      <= rd_r | rd_start; // see R01
            rd_cnt_r  <= rd_r ? rd_cnt_r + 3'h1 : 3'h0;
            // Fresh snapshot at every byte boundary so polling sees progress
            if (rd_start || (rd_r && rd_cnt_r == `RD_BIT_LAST)) begin
                out_sh_r <= snap_r; // see R23
            end else begin
                out_sh_r <= {out_sh_r[6:0], 1'b0};
            end
        end
    end

    // Command words stay put until the next command, well past the core sync
    always_ff @(posedge sck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_hold_r  <= 8'h0;
            data_hold_r <= 8'h0;
            cmd_tgl_r   <= 1'b0;
            lq_r        <= 3'h0;
            link_ack_r  <= 1'b0;
            snap_r      <= 8'h0;
        end else begin
            if (fire_one) begin
                cmd_hold_r <= byte_in;
                cmd_tgl_r  <= ~cmd_tgl_r;
            end else if (fire_two) begin
                cmd_hold_r  <= shift_r[14:7];
                data_hold_r <= byte_in;
                cmd_tgl_r   <= ~cmd_tgl_r;
            end
            lq_r <= {lq_r[1:0], st_req_r};
            if (lq_new) begin
                snap_r     <= st_word_r;
                link_ack_r <= lq_r[2];
            end
        end
    end

    always_ff @(negedge sck_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            miso_o    <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            miso_o    <= rd_r & out_sh_r[7];
            miso_oe_o <= rd_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: synchronisers for command toggle, snapshot ack, protect pin
    logic [2:0] sy0_r;
    logic [2:0] sy1_r;
    logic [2:0] sy2_r;
    logic [2:0] settled_r;
    wire  [2:0] agree       = ~(sy1_r ^ sy2_r);
    wire  [2:0] settled_nxt = (sy2_r & agree) | (settled_r & ~agree);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sy0_r     <= `SYNC_RST;
            sy1_r     <= `SYNC_RST;
            sy2_r     <= `SYNC_RST;
            settled_r <= `SYNC_RST;
        end else begin
            sy0_r     <= {wp_n_i, link_ack_r, cmd_tgl_r};
            sy1_r     <= sy0_r;
            sy2_r     <= sy1_r;
            settled_r <= settled_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command filter
    op_state_t  state_r;
    op_state_t  state_nxt;
    op_kind_t   kind_r;
    op_kind_t   kind_nxt;
    logic       wel_r;
    logic       wel_nxt;
    logic       perr_r;
    logic       perr_nxt;
    logic       eerr_r;
    logic       eerr_nxt;
    logic       lock_r;
    logic [2:0] prot_vol_r;
    logic [2:0] prot_nv_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       start_nxt;

    wire       cmd_go    = agree[0] && (sy2_r[0] != settled_r[0]);
    wire [7:0] cmd       = cmd_hold_r;
    wire       idle      = (state_r == ST_IDLE);
    wire       taken     = cmd_go && (idle || busy_ok(cmd)); // see R17
    wire       hw_locked = lock_r & ~settled_r[2]; // see R08
    wire [2:0] prot_cur  = protect_volatility_sel_i ? prot_vol_r : prot_nv_r; // see R14
    wire       c_write_enable_cmd    = taken && (cmd == `CMD_WRITE_ENABLE);
    wire       c_write_disable_cmd    = taken && (cmd == `CMD_WRITE_DISABLE);
    wire       c_clear_status_cmd    = taken && (cmd == `CMD_CLEAR_STATUS);
    wire       c_rst     = taken && (cmd == `CMD_SOFT_RESET);
    wire       c_wrr     = taken && idle && wel_r && !hw_locked // see R03 R09
                        && (cmd == `CMD_REGISTER_WRITE);
    wire       bulk_cmd  = (cmd == `CMD_WHOLE_ERASE);
    // Whole erase with any protect bit set is dropped silently, no flag
    wire       c_arr     = taken && idle && wel_r && is_array(cmd) // see R03
                        && !(bulk_cmd && prot_cur != `PROT_NONE); // see R12 R16
    wire       arr_hit   = !bulk_cmd && sector_protected_i; // see R22
    op_kind_t  arr_kind;
    assign arr_kind = bulk_cmd ? KIND_BULK
                    : (cmd == `CMD_PROGRAM) ? KIND_PROG : KIND_SECT;
    wire       in_array  = (state_r == ST_ARRAY);
    wire       c_erase_suspend_cmd    = taken && in_array && (kind_r != KIND_PROG) // see R18
                        && (cmd == `CMD_ERASE_SUSPEND);
    wire       c_program_suspend_cmd    = taken && in_array && (kind_r == KIND_PROG) // see R18
                        && (cmd == `CMD_PROGRAM_SUSPEND);
    wire       arr_fail  = in_array && op_fail_i;
    wire       hit_now   = idle && c_arr && arr_hit;
    wire       perr_set  = (hit_now && arr_kind == KIND_PROG) // see R10
                        || (arr_fail && kind_r == KIND_PROG);
    wire       eerr_set  = (hit_now && arr_kind == KIND_SECT) // see R11
                        || (arr_fail && kind_r != KIND_PROG);
    wire       prot_we   = c_wrr && !config_freeze_i; // see R21

    always_comb begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        wel_nxt   = wel_r;
        perr_nxt  = perr_r;
        eerr_nxt  = eerr_r;
        start_nxt = 1'b0;
        cnt_nxt   = (cnt_r != 8'h0) ? cnt_r - 8'h1 : cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (c_wrr) begin
                    state_nxt = ST_REG; // see R04
                    cnt_nxt   = 8'(`REG_WRITE_CYCLES);
                end else if (c_arr) begin
                    kind_nxt = arr_kind;
                    if (arr_hit) begin
                        state_nxt = ST_HALT; // see R16
                    end else begin
                        state_nxt = ST_ARRAY;
                        start_nxt = 1'b1;
                    end
                end
            end
            ST_REG: begin
                if (cnt_r == 8'h0) begin
                    state_nxt = ST_IDLE;
                    wel_nxt   = 1'b0; // see R05
                end
            end
            ST_ARRAY: begin
                if (op_fail_i) begin
                    state_nxt = ST_HALT; // see R19
                end else if (op_done_i) begin
                    state_nxt = ST_IDLE;
                    wel_nxt   = 1'b0; // see R05
                end
            end
            ST_HALT: begin
                if (c_clear_status_cmd) begin
                    state_nxt = ST_IDLE; // see R19
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (c_write_enable_cmd) begin
            wel_nxt = 1'b1; // see R02
        end
        if (c_write_disable_cmd) begin
            wel_nxt = 1'b0; // see R02
        end
        if (c_clear_status_cmd) begin
            perr_nxt = 1'b0; // see R13
            eerr_nxt = 1'b0;
        end
        // A failure in the clear-status cycle still lands
        if (perr_set) begin
            perr_nxt = 1'b1;
        end
        if (eerr_set) begin
            eerr_nxt = 1'b1;
        end
        if (c_rst) begin
            state_nxt = ST_IDLE;
            wel_nxt   = 1'b0; // see R06 R20
            perr_nxt  = 1'b0;
            eerr_nxt  = 1'b0;
        end
    end

    wire [7:0] status_nxt = {lock_r, perr_r, eerr_r, prot_cur, wel_r, !idle}; // see R01
    wire       st_send    = (settled_r[1] == st_req_r);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_IDLE;
            kind_r  <= KIND_PROG;
            wel_r   <= 1'b0; // see R06
            perr_r  <= 1'b0;
            eerr_r  <= 1'b0;
            cnt_r   <= 8'h0;
        end else begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            wel_r   <= wel_nxt;
            perr_r  <= perr_nxt;
            eerr_r  <= eerr_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Non-volatile bits only see the power-on value here; soft reset spares them
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_r     <= 1'b0;
            prot_vol_r <= `PROT_VOL_RST; // see R15
            prot_nv_r  <= `PROT_NV_RST;
        end else begin
            if (c_wrr) begin
                lock_r <= data_hold_r[`SB_LOCK]; // see R09
            end
            if (c_rst) begin
                prot_vol_r <= `PROT_VOL_RST; // see R20
            end else if (prot_we && protect_volatility_sel_i) begin
                prot_vol_r <= data_hold_r[`SB_PROT_HI:`SB_PROT_LO];
            end
            if (prot_we && !protect_volatility_sel_i) begin
                prot_nv_r <= data_hold_r[`SB_PROT_HI:`SB_PROT_LO];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_byte_o     <= 8'h0;
            op_start_o        <= 1'b0;
            op_kind_o         <= KIND_PROG;
            erase_suspend_o   <= 1'b0;
            program_suspend_o <= 1'b0;
            st_word_r         <= 8'h0;
            st_req_r          <= 1'b0;
        end else begin
            status_byte_o     <= status_nxt;
            op_start_o        <= start_nxt;
            op_kind_o         <= kind_nxt;
            erase_suspend_o   <= c_erase_suspend_cmd;
            program_suspend_o <= c_program_suspend_cmd;
            if (st_send) begin
                st_word_r <= status_nxt; // see R23
                st_req_r  <= ~st_req_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_write_enable_cmd_sets_latch: assert property (c_write_enable_cmd |=> wel_r) // see R02
        else $error("write enable did not set latch");
    a_write_disable_cmd_clear_latch: assert property (c_write_disable_cmd |=> !wel_r) // see R02
        else $error("write disable did not clear latch");
    a_latch_gates_ops: assert property ($rose(op_start_o) |-> $past(wel_r, 1)) // see R03
        else $error("array op started with latch clear");
    a_wrr_keeps_latch: assert property (c_wrr |=> wel_r [*8]) // see R04
        else $error("register write changed latch");
    a_done_clear_latch: assert property (in_array && op_done_i && !op_fail_i // see R05
        |=> idle && !wel_r)
        else $error("completion did not clear latch");
    a_hw_lock_refuse: assert property (cmd_go && cmd == `CMD_REGISTER_WRITE // see R08
        && hw_locked |=> $stable(lock_r) && state_r == $past(state_r))
        else $error("locked register write accepted");
    a_prog_fail_flag: assert property (arr_fail && kind_r == KIND_PROG // see R10
        |=> perr_r && state_r == ST_HALT)
        else $error("program failure not flagged");
    a_whole_no_flag: assert property (cmd_go && bulk_cmd && prot_cur != `PROT_NONE // see R12
        && !in_array |=> $stable(eerr_r) && !op_start_o)
        else $error("protected whole erase acted");
    a_error_keeps_busy: assert property ((perr_r || eerr_r) |-> status_nxt[`SB_BUSY]) // see R19
        else $error("error flag without busy");
    a_busy_filter: assert property (!idle && cmd_go && cmd == `CMD_WRITE_DISABLE // see R17
        |=> $stable(wel_r))
        else $error("busy accepted write disable");
    a_clear_status_cmd_clears: assert property (c_clear_status_cmd && !arr_fail && !hit_now // see R13
        |=> !perr_r && !eerr_r)
        else $error("clear status left a flag");
    a_freeze_holds: assert property (config_freeze_i && !c_rst // see R21
        |=> $stable(prot_vol_r) && $stable(prot_nv_r))
        else $error("frozen protect bits changed");

    c_prog_done: cover property (op_start_o ##[1:200] (in_array && op_done_i));
    c_fail_then_clear: cover property (arr_fail ##[1:300] c_clear_status_cmd);
    c_reg_write_done: cover property (c_wrr ##[120:130] idle);
    c_status_poll: cover property (!idle && cmd_go && cmd == `CMD_READ_STATUS);

endmodule : flash_status_register_logic

// >>> verif/host_spi_model.sv
// Host controller model: mode 0 serial frames, commands and status reads
module host_spi_model (
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    input  wire logic miso_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 7.5;

    // Link clock stands still low between frames
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic shift(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = b[i];
            #HALF sck_o = 1'b1;
            #HALF sck_o = 1'b0;
        end
    endtask : shift

    task automatic open_frame;
        cs_n_o = 1'b0;
        #HALF;
    endtask : open_frame

    // Data line left toggled, and eight idle periods before the next command
    task automatic close_frame;
        #HALF cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #(16 * HALF);
    endtask : close_frame

    task automatic cmd(input logic [7:0] op);
        open_frame();
        shift(op);
        close_frame();
    endtask : cmd

    task automatic register_write_cmd(input logic [7:0] data);
        open_frame();
        shift(8'h01);
        shift(data);
        close_frame();
    endtask : register_write_cmd

    // Undriven reply bits come back unknown so they can never match
    task automatic rdsr(input logic [7:0] op, output logic [7:0] rd);
        open_frame();
        shift(op);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = ~mosi_o;
            #HALF sck_o = 1'b1;
            rd[i] = miso_oe_i ? miso_i : 1'bx;
            #HALF sck_o = 1'b0;
        end
        close_frame();
    endtask : rdsr
endmodule : host_spi_model

// >>> verif/test_flash_status_register_logic.sv
// Self-checking bench for the status register logic
module test_flash_status_register_logic;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_status_pkg::*;

    logic       clk = 1'b0;
    logic       resetn;
    logic       wp_n;
    logic       vol_sel;
    logic       freeze;
    logic       sect_prot;
    logic       op_done;
    logic       op_fail;
    wire logic  sck, cs_n, mosi, miso, miso_oe, op_start, e_susp, p_susp;
    wire logic [7:0] status;
    op_kind_t   kind;
    op_kind_t   last_kind;
    logic [7:0] rd;
    int         fail_count = 0;
    int         cmp_count = 0;
    int         starts = 0;
    int         esusp = 0;
    int         psusp = 0;

    always #4 clk = ~clk;

    flash_status_register_logic dut (
        .clk_i                    (clk),
        .resetn_i                 (resetn),
        .sck_i                    (sck),
        .cs_n_i                   (cs_n),
        .mosi_i                   (mosi),
        .wp_n_i                   (wp_n),
        .protect_volatility_sel_i (vol_sel),
        .config_freeze_i          (freeze),
        .sector_protected_i       (sect_prot),
        .op_done_i                (op_done),
        .op_fail_i                (op_fail),
        .miso_o                   (miso),
        .miso_oe_o                (miso_oe),
        .status_byte_o            (status),
        .op_start_o               (op_start),
        .op_kind_o                (kind),
        .erase_suspend_o          (e_susp),
        .program_suspend_o        (p_susp)
    );

    host_spi_model host (
        .sck_o     (sck),
        .cs_n_o    (cs_n),
        .mosi_o    (mosi),
        .miso_i    (miso),
        .miso_oe_i (miso_oe)
    );

    // Pulses last one cycle; counted mid-cycle, clear of the launching edge
    always @(negedge clk) begin
        if (op_start === 1'b1) begin
            starts++;
            last_kind = kind;
        end
        if (e_susp === 1'b1) esusp++;
        if (p_susp === 1'b1) psusp++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask : clks

    task automatic wait_idle;
        int i;
        for (i = 0; i < 300 && status[0] !== 1'b0; i++) clks(1);
        if (i == 300) begin
            fail_count++;
            $display("CHECK FAILED at %0t: busy never cleared", $time);
            tally_and_finish();
        end
        clks(4);
    endtask : wait_idle

    task automatic pulse(input logic ok);
        @(negedge clk);
        if (ok) op_done = 1'b1;
        else op_fail = 1'b1;
        @(negedge clk);
        op_done = 1'b0;
        op_fail = 1'b0;
        clks(8);
    endtask : pulse

    task automatic do_reset;
        @(negedge clk);
        resetn = 1'b0;
        clks(8);
        resetn = 1'b1;
        clks(4);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_latch;
        check(status, 8'h1c, "reset value");
        host.rdsr(8'h05, rd);
        check(rd, 8'h1c, "read 05h");
        host.rdsr(8'h07, rd);
        check(rd, 8'h1c, "read 07h");
        host.register_write_cmd(8'h00);
        check(status, 8'h1c, "write with latch low");
        host.cmd(8'h02);
        check(8'(starts), 8'h00, "program with latch low");
        host.cmd(8'h06);
        check(status, 8'h1e, "latch set");
        host.cmd(8'h04);
        check(status, 8'h1c, "latch cleared");
    endtask : t_reset_and_latch

    // Lock with protect pin low must refuse, pin high must accept
    task automatic t_register_write;
        host.cmd(8'h06);
        host.register_write_cmd(8'h80);
        check(status, 8'h83, "write busy");
        wait_idle();
        check(status, 8'h80, "write done");
        wp_n = 1'b0;
        host.cmd(8'h06);
        host.register_write_cmd(8'h00);
        check(status, 8'h82, "hardware protected");
        @(negedge clk) wp_n = 1'b1;
        host.register_write_cmd(8'h00);
        host.rdsr(8'h05, rd);
        check(rd, 8'h03, "poll while busy");
        wait_idle();
        check(status, 8'h00, "unlocked write");
    endtask : t_register_write

    task automatic t_program;
        host.cmd(8'h06);
        host.cmd(8'h02);
        check(8'(starts), 8'h01, "program start");
        check({6'h0, last_kind}, {6'h0, KIND_PROG}, "program kind");
        host.cmd(8'h04);
        check(status, 8'h03, "disable ignored when busy");
        host.cmd(8'h75);
        host.cmd(8'h85);
        check(8'(esusp), 8'h00, "erase suspend in program");
        check(8'(psusp), 8'h01, "program suspend");
        pulse(1'b1);
        check(status, 8'h00, "program done");
        host.cmd(8'h06);
        host.cmd(8'h02);
        pulse(1'b0);
        check(status, 8'h43, "program failed");
        host.register_write_cmd(8'h00);
        check(status, 8'h43, "write while failed");
        host.cmd(8'h30);
        check(status, 8'h02, "status cleared");
        host.cmd(8'h04);
        check(status, 8'h00, "latch dropped");
    endtask : t_program

    task automatic t_erase;
        @(negedge clk) sect_prot = 1'b1;
        host.cmd(8'h06);
        host.cmd(8'hd8);
        check(status, 8'h23, "protected sector erase");
        host.cmd(8'h75);
        check(8'(esusp) | 8'(starts - 2), 8'h00, "no engine start");
        host.cmd(8'h30);
        host.cmd(8'h04);
        host.cmd(8'h06);
        host.register_write_cmd(8'h04);
        wait_idle();
        host.cmd(8'h06);
        host.cmd(8'hc7);
        check(status, 8'h06, "whole erase refused");
        host.register_write_cmd(8'h00);
        wait_idle();
        host.cmd(8'h06);
        host.cmd(8'hc7);
        check({6'h0, last_kind}, {6'h0, KIND_BULK}, "whole erase kind");
        host.cmd(8'h75);
        check(8'(esusp), 8'h01, "erase suspend");
        pulse(1'b1);
        check(status, 8'h00, "whole erase over protection");
        @(negedge clk) sect_prot = 1'b0;
    endtask : t_erase

    // Software reset keeps non-volatile protection but restores volatile defaults
    task automatic t_freeze_and_resets;
        @(negedge clk) freeze = 1'b1;
        host.cmd(8'h06);
        host.register_write_cmd(8'h1c);
        wait_idle();
        check(status, 8'h00, "frozen protect bits");
        @(negedge clk) freeze = 1'b0;
        host.cmd(8'h06);
        host.cmd(8'hf0);
        check(status, 8'h1c, "soft reset volatile");
        @(negedge clk) vol_sel = 1'b0;
        do_reset();
        check(status, 8'h00, "non-volatile default");
        host.cmd(8'h06);
        host.register_write_cmd(8'h08);
        wait_idle();
        host.cmd(8'h06);
        host.cmd(8'hf0);
        check(status, 8'h08, "soft reset non-volatile");
    endtask : t_freeze_and_resets

    initial begin
        resetn    = 1'b0;
        wp_n      = 1'b1;
        vol_sel   = 1'b1;
        freeze    = 1'b0;
        sect_prot = 1'b0;
        op_done   = 1'b0;
        op_fail   = 1'b0;
        do_reset();
        t_reset_and_latch();
        t_register_write();
        t_program();
        t_erase();
        t_freeze_and_resets();
        tally_and_finish();
    end
endmodule : test_flash_status_register_logic
